// *** design/stats_pkg.sv ***
/*
  Constants of the traffic statistics block: widths, counter indices,
  length limits and reset values.
  Assumes one clock and a synchronous active-high reset.
*/
package stats_pkg;

  // Ports and widths
  localparam int NUM_PORTS  = 10;                  // Switch ports
  localparam int PORT_W     = 4;                   // Port number width
  localparam int NUM_CNT    = 25;                  // Counters per port
  localparam int CNT_SEL_W  = 5;                   // Counter index width
  localparam int CNT_W      = 32;                  // Counter width
  localparam int LEN_W      = 11;                  // Frame length width
  localparam int ADDR_W     = 9;                   // Counter RAM address

  // Low-speed ports start here; ports below are 10/100 capable
  localparam logic [PORT_W-1:0] FIRST_SLOW_PORT = 4'h2;

  // Frame-length limits in octets, check sequence included
  localparam logic [LEN_W-1:0] LEN_64    = 11'h040;
  localparam logic [LEN_W-1:0] LEN_65    = 11'h041;
  localparam logic [LEN_W-1:0] LEN_127   = 11'h07f;
  localparam logic [LEN_W-1:0] LEN_128   = 11'h080;
  localparam logic [LEN_W-1:0] LEN_255   = 11'h0ff;
  localparam logic [LEN_W-1:0] LEN_256   = 11'h100;
  localparam logic [LEN_W-1:0] LEN_511   = 11'h1ff;
  localparam logic [LEN_W-1:0] LEN_512   = 11'h200;
  localparam logic [LEN_W-1:0] LEN_1023  = 11'h3ff;
  localparam logic [LEN_W-1:0] LEN_1024  = 11'h400;
  localparam logic [LEN_W-1:0] LEN_1518  = 11'h5ee;
  localparam logic [LEN_W-1:0] LEN_1535  = 11'h5ff;

  // Value of every counter after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

  // Counter indices within one port's bank
  localparam logic [CNT_SEL_W-1:0] C_RX_BCAST    = 5'h00;
  localparam logic [CNT_SEL_W-1:0] C_TX_BCAST    = 5'h01;
  localparam logic [CNT_SEL_W-1:0] C_RX_MCAST    = 5'h02;
  localparam logic [CNT_SEL_W-1:0] C_TX_MCAST    = 5'h03;
  localparam logic [CNT_SEL_W-1:0] C_CRS_ERR     = 5'h04;
  localparam logic [CNT_SEL_W-1:0] C_COLLISIONS  = 5'h05;
  localparam logic [CNT_SEL_W-1:0] C_DEFERRED    = 5'h06;
  localparam logic [CNT_SEL_W-1:0] C_EXCESS_COL  = 5'h07;
  localparam logic [CNT_SEL_W-1:0] C_FILTERED    = 5'h08;
  localparam logic [CNT_SEL_W-1:0] C_RX_GOOD     = 5'h09;
  localparam logic [CNT_SEL_W-1:0] C_TX_GOOD     = 5'h0a;
  localparam logic [CNT_SEL_W-1:0] C_LATE_COL    = 5'h0b;
  localparam logic [CNT_SEL_W-1:0] C_MULTI_COL   = 5'h0c;
  localparam logic [CNT_SEL_W-1:0] C_SINGLE_COL  = 5'h0d;
  localparam logic [CNT_SEL_W-1:0] C_NET_OCTETS  = 5'h0e;
  localparam logic [CNT_SEL_W-1:0] C_OVERSIZE    = 5'h0f;
  localparam logic [CNT_SEL_W-1:0] C_ALIGN_CODE  = 5'h10;
  localparam logic [CNT_SEL_W-1:0] C_LEN_64      = 5'h11;
  localparam logic [CNT_SEL_W-1:0] C_LEN_65_127  = 5'h12;
  localparam logic [CNT_SEL_W-1:0] C_LEN_128_255 = 5'h13;
  localparam logic [CNT_SEL_W-1:0] C_LEN_256_511 = 5'h14;
  localparam logic [CNT_SEL_W-1:0] C_LEN_512_1K  = 5'h15;
  localparam logic [CNT_SEL_W-1:0] C_LEN_1K_MAX  = 5'h16;
  localparam logic [CNT_SEL_W-1:0] C_ADDR_DUP    = 5'h17;
  localparam logic [CNT_SEL_W-1:0] C_ADDR_CHG    = 5'h18;

  // Counter RAM clear walker: one-hot states
  typedef enum logic [1:0] {
    ST_CLEAR = 2'b01,
    ST_RUN   = 2'b10
  } walk_state_t;

endpackage : stats_pkg

// *** design/stats_ram.sv ***
/*
  Counter RAM: one write and one registered read port per cycle.
  Assumes no read of a word in the cycle it is written.
*/
`timescale 1ns/10ps
module stats_ram
  import stats_pkg::*;
(
  // Clock
  input  wire logic              mclk_i,
  // Write side
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [CNT_W-1:0]  wr_data_i,
  // Read side
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [CNT_W-1:0]  rd_data_o
);

  // Storage array, one word per port and counter
  logic [CNT_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Write port and registered read port
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : stats_ram

// *** design/port_traffic_statistics.sv ***
/*
  Per-port traffic statistics for a ten-port switch. Each port reports
  receive and transmit frame completions and MAC events as one-cycle
  pulses; the block classifies them and bumps counters held in a RAM.
  Once ready_o is high, a read port returns any counter two cycles after the request.
  Assumes inputs synchronous to mclk_i and one pulse per event.
*/
// Behaviour
// - Count good broadcast receive frames per port
// - Count broadcast transmit frames per port
// - Count good multicast receive frames, not broadcast
// - Count multicast transmit frames, not broadcast
// - Carrier-sense errors counted once per attempt
// - Low-speed ports count jam sequences sent
// - Count frames deferred on first attempt
// - Count frames dropped on excess collisions
// - Count every frame sent to discard
// - Count all good receive frames
// - Count all completed transmit frames
// - Count collisions after 512 bit times
// - Count multiple and single collision frames
// - Sum all received octets including bad
// - Count oversize good frames, long bit
// - Align errors; fast ports add receive errors
// - Count frames exactly 64 octets, both directions
// - Count length buckets 65 to 1023
// - Count secure address duplications, suspend port
// - Address changes add mismatches and learns
// - Count 1024 to 1518 or 1535 frames
`timescale 1ns/10ps
module port_traffic_statistics
  import stats_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  // Configuration
  input  wire logic                 long_frames_i,
  input  wire logic [NUM_PORTS-1:0] fast_mode_i,
  // Receive frame completion, per port
  input  wire logic [NUM_PORTS-1:0] rx_done_i,
  input  wire logic [NUM_PORTS-1:0] rx_good_i,
  input  wire logic [NUM_PORTS-1:0] rx_bcast_i,
  input  wire logic [NUM_PORTS-1:0] rx_mcast_i,
  input  wire logic [NUM_PORTS-1:0] rx_align_err_i,
  input  wire logic [NUM_PORTS-1:0] rx_code_err_i,
  input  wire logic [NUM_PORTS-1:0] rx_discard_i,
  input  wire logic [NUM_PORTS*LEN_W-1:0] rx_len_i,
  // Transmit frame completion, per port
  input  wire logic [NUM_PORTS-1:0] tx_done_i,
  input  wire logic [NUM_PORTS-1:0] tx_bcast_i,
  input  wire logic [NUM_PORTS-1:0] tx_mcast_i,
  input  wire logic [NUM_PORTS-1:0] tx_deferred_i,
  input  wire logic [NUM_PORTS-1:0] tx_single_col_i,
  input  wire logic [NUM_PORTS-1:0] tx_multi_col_i,
  input  wire logic [NUM_PORTS*LEN_W-1:0] tx_len_i,
  // Transmit attempt events, per port
  input  wire logic [NUM_PORTS-1:0] tx_attempt_start_i,
  input  wire logic [NUM_PORTS-1:0] tx_carrier_lost_i,
  input  wire logic [NUM_PORTS-1:0] tx_jam_i,
  input  wire logic [NUM_PORTS-1:0] tx_late_col_i,
  input  wire logic [NUM_PORTS-1:0] tx_excess_col_i,
  // Address table events, per port
  input  wire logic [NUM_PORTS-1:0] addr_secure_dup_i,
  input  wire logic [NUM_PORTS-1:0] addr_learned_i,
  // Counter read port
  input  wire logic                 rd_req_i,
  input  wire logic [PORT_W-1:0]    rd_port_i,
  input  wire logic [CNT_SEL_W-1:0] rd_cnt_i,
  output logic                      rd_valid_o,
  output logic      [CNT_W-1:0]     rd_data_o,
  // Status
  output logic      [NUM_PORTS-1:0] port_suspend_o,
  output logic                      ready_o
);

  // Event vector per port, one bit per counter
  logic [NUM_CNT-1:0] evt       [NUM_PORTS];
  logic [LEN_W-1:0]   rx_oct    [NUM_PORTS];
  // Pending increments and octet accumulators per port
  logic [NUM_CNT-1:0] pend_ff   [NUM_PORTS];
  logic [NUM_CNT-1:0] nxt_pend  [NUM_PORTS];
  logic [CNT_W-1:0]   oct_ff    [NUM_PORTS];
  logic [CNT_W-1:0]   nxt_oct   [NUM_PORTS];
  // Carrier error already counted in this attempt
  logic [NUM_PORTS-1:0] crs_seen_ff;
  logic [NUM_PORTS-1:0] nxt_crs_seen;
  // Suspend flags
  logic [NUM_PORTS-1:0] susp_ff;
  logic [NUM_PORTS-1:0] nxt_susp;

  // Event classification, one copy per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [LEN_W-1:0] rl;     // Receive length
    logic [LEN_W-1:0] tl;     // Transmit length
    logic [LEN_W-1:0] lmax;   // Largest non-oversize length
    logic             rxe;    // Align or code error qualifying
    logic             slow;   // Low-speed port
    assign rl   = rx_len_i[p*LEN_W +: LEN_W];
    assign tl   = tx_len_i[p*LEN_W +: LEN_W];
    assign lmax = long_frames_i ? LEN_1535 : LEN_1518;
    assign slow = (PORT_W'(p) >= FIRST_SLOW_PORT);
    // Code errors only count on ports running at 100 Mbit/s
    assign rxe  = rx_align_err_i[p] |
                  (fast_mode_i[p] & ~slow & rx_code_err_i[p]);
    assign rx_oct[p] = rl;

    always_comb begin
      evt[p] = '0;
      // Receive side classes
      if (rx_done_i[p]) begin
        evt[p][C_RX_BCAST] = rx_good_i[p] & rx_bcast_i[p];
        evt[p][C_RX_MCAST] = rx_good_i[p] & rx_mcast_i[p]
                             & ~rx_bcast_i[p];
        evt[p][C_RX_GOOD]  = rx_good_i[p];
        evt[p][C_FILTERED] = rx_discard_i[p];
        evt[p][C_OVERSIZE] = rx_good_i[p] & (rl > lmax);
        evt[p][C_ALIGN_CODE] = rxe;
      end
      // Transmit side classes
      if (tx_done_i[p]) begin
        evt[p][C_TX_BCAST]  = tx_bcast_i[p];
        evt[p][C_TX_MCAST]  = tx_mcast_i[p] & ~tx_bcast_i[p];
        evt[p][C_TX_GOOD]   = 1'b1;
        evt[p][C_DEFERRED]  = tx_deferred_i[p];
        evt[p][C_SINGLE_COL] = tx_single_col_i[p];
        evt[p][C_MULTI_COL] = tx_multi_col_i[p]
                              & ~tx_single_col_i[p];
      end
      // Length buckets shared by both directions
      evt[p][C_LEN_64] = (rx_done_i[p] & (rl == LEN_64)) |
                         (tx_done_i[p] & (tl == LEN_64));
      evt[p][C_LEN_65_127] =
        (rx_done_i[p] & (rl >= LEN_65) & (rl <= LEN_127)) |
        (tx_done_i[p] & (tl >= LEN_65) & (tl <= LEN_127));
      evt[p][C_LEN_128_255] =
        (rx_done_i[p] & (rl >= LEN_128) & (rl <= LEN_255)) |
        (tx_done_i[p] & (tl >= LEN_128) & (tl <= LEN_255));
      evt[p][C_LEN_256_511] =
        (rx_done_i[p] & (rl >= LEN_256) & (rl <= LEN_511)) |
        (tx_done_i[p] & (tl >= LEN_256) & (tl <= LEN_511));
      evt[p][C_LEN_512_1K] =
        (rx_done_i[p] & (rl >= LEN_512) & (rl <= LEN_1023)) |
        (tx_done_i[p] & (tl >= LEN_512) & (tl <= LEN_1023));
      evt[p][C_LEN_1K_MAX] =
        (rx_done_i[p] & (rl >= LEN_1024) & (rl <= lmax)) |
        (tx_done_i[p] & (tl >= LEN_1024) & (tl <= lmax));
      // Attempt and address table events
      evt[p][C_CRS_ERR] = tx_carrier_lost_i[p] & ~crs_seen_ff[p]
                          & ~tx_attempt_start_i[p];
      evt[p][C_COLLISIONS] = slow & tx_jam_i[p];
      evt[p][C_LATE_COL]   = tx_late_col_i[p];
      evt[p][C_EXCESS_COL] = tx_excess_col_i[p];
      evt[p][C_ADDR_DUP] = addr_secure_dup_i[p];
      evt[p][C_ADDR_CHG] = addr_secure_dup_i[p];
    end
  end

  // Scan pointer walking every port and counter
  logic [PORT_W-1:0]    sp_ff,  nxt_sp;
  logic [CNT_SEL_W-1:0] sc_ff,  nxt_sc;
  logic [ADDR_W-1:0]    clr_ff, nxt_clr;
  walk_state_t          st_ff,  nxt_st;
  // Pipeline: stage 1 has read issued, stage 2 has data
  logic                 s1_ff,  nxt_s1;
  logic [ADDR_W-1:0]    a1_ff,  nxt_a1;
  logic [CNT_W-1:0]     d1_ff,  nxt_d1;   // Increment amount
  logic                 rdq_ff, nxt_rdq;  // Read request in flight
  logic                 rdv_ff, nxt_rdv;
  logic [CNT_W-1:0]     rdd_ff, nxt_rdd;
  logic [ADDR_W-1:0]    rd_addr;
  logic [CNT_W-1:0]     ram_q;
  logic                 wr_en;
  logic [ADDR_W-1:0]    wr_addr;
  logic [CNT_W-1:0]     wr_data;
  logic                 sel_pend;

  // Address of a port and counter in the RAM
  function automatic logic [ADDR_W-1:0] cnt_addr(
    input logic [PORT_W-1:0] port, input logic [CNT_SEL_W-1:0] cnt);
    cnt_addr = ADDR_W'({port, cnt});
  endfunction : cnt_addr

  // Pending bits, octet accumulators, carrier and suspend next state
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      nxt_pend[p] = pend_ff[p] | evt[p];
      nxt_oct[p]  = oct_ff[p];
      // Drain the counter under the scan pointer; new events win
      if (st_ff == ST_RUN && sp_ff == PORT_W'(p) && !rd_req_i) begin
        nxt_pend[p][sc_ff] = evt[p][sc_ff];
        if (sc_ff == C_NET_OCTETS) begin
          nxt_oct[p] = CNT_W'(0);
        end
      end
      if (rx_done_i[p]) begin
        nxt_pend[p][C_NET_OCTETS] = 1'b1;
        nxt_oct[p] = nxt_oct[p] + CNT_W'(rx_oct[p]);
      end
      // Carrier error window ends at the next attempt
      nxt_crs_seen[p] = tx_attempt_start_i[p] ? 1'b0 :
                        (crs_seen_ff[p] | tx_carrier_lost_i[p]);
      // Port stays suspended until reset
      nxt_susp[p] = susp_ff[p] | addr_secure_dup_i[p];
    end
  end

  // Learn events share the address counter with mismatches
  logic [NUM_PORTS-1:0] learn_ff, nxt_learn;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      nxt_learn[p] = learn_ff[p] | addr_learned_i[p];
      if (st_ff == ST_RUN && sp_ff == PORT_W'(p) && !rd_req_i &&
          sc_ff == C_ADDR_CHG) begin
        nxt_learn[p] = addr_learned_i[p];
      end
    end
  end

  // Scan, clear walk and counter update pipeline
  always_comb begin
    nxt_st  = st_ff;
    nxt_clr = clr_ff;
    nxt_sp  = sp_ff;
    nxt_sc  = sc_ff;
    nxt_s1  = 1'b0;
    nxt_a1  = a1_ff;
    nxt_d1  = d1_ff;
    nxt_rdq = 1'b0;
    nxt_rdv = rdq_ff;
    nxt_rdd = rdq_ff ? ram_q : rdd_ff;
    rd_addr = cnt_addr(sp_ff, sc_ff);
    wr_en   = 1'b0;
    wr_addr = a1_ff;
    wr_data = ram_q + d1_ff;
    sel_pend = 1'b0;
    case (st_ff)
      ST_CLEAR: begin
        // Zero every RAM word after reset
        wr_en   = 1'b1;
        wr_addr = clr_ff;
        wr_data = CNT_RESET;
        nxt_clr = clr_ff + ADDR_W'(1);
        if (clr_ff == '1) begin
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        // Write back the increment read one cycle ago
        wr_en = s1_ff;
        if (rd_req_i) begin
          // Host read takes the RAM port this cycle
          rd_addr = cnt_addr(rd_port_i, rd_cnt_i);
          nxt_rdq = 1'b1;
        end else begin
          sel_pend = pend_ff[sp_ff][sc_ff] ||
                     (sc_ff == C_ADDR_CHG && learn_ff[sp_ff]);
          // Skip the address still being written back
          if (sel_pend && !(s1_ff && a1_ff == rd_addr)) begin
            nxt_s1 = 1'b1;
            nxt_a1 = rd_addr;
            if (sc_ff == C_NET_OCTETS) begin
              nxt_d1 = oct_ff[sp_ff];
            end else if (sc_ff == C_ADDR_CHG) begin
              nxt_d1 = CNT_W'(pend_ff[sp_ff][sc_ff]) +
                       CNT_W'(learn_ff[sp_ff]);
            end else begin
              nxt_d1 = CNT_W'(1);
            end
          end
          // Advance the scan pointer across counters and ports
          if (sc_ff == CNT_SEL_W'(NUM_CNT - 1)) begin
            nxt_sc = '0;
            nxt_sp = (sp_ff == PORT_W'(NUM_PORTS - 1)) ? '0
                     : sp_ff + PORT_W'(1);
          end else begin
            nxt_sc = sc_ff + CNT_SEL_W'(1);
          end
        end
      end
      default: begin
        nxt_st = ST_CLEAR;
      end
    endcase
  end

  // Register every piece of state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pend_ff[p] <= '0;
        oct_ff[p]  <= CNT_RESET;
      end
      crs_seen_ff <= '0;
      susp_ff     <= '0;
      learn_ff    <= '0;
      st_ff       <= ST_CLEAR;
      clr_ff      <= '0;
      sp_ff       <= '0;
      sc_ff       <= '0;
      s1_ff       <= 1'b0;
      a1_ff       <= '0;
      d1_ff       <= CNT_RESET;
      rdq_ff      <= 1'b0;
      rdv_ff      <= 1'b0;
      rdd_ff      <= CNT_RESET;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pend_ff[p] <= nxt_pend[p];
        oct_ff[p]  <= nxt_oct[p];
      end
      crs_seen_ff <= nxt_crs_seen;
      susp_ff     <= nxt_susp;
      learn_ff    <= nxt_learn;
      st_ff       <= nxt_st;
      clr_ff      <= nxt_clr;
      sp_ff       <= nxt_sp;
      sc_ff       <= nxt_sc;
      s1_ff       <= nxt_s1;
      a1_ff       <= nxt_a1;
      d1_ff       <= nxt_d1;
      rdq_ff      <= nxt_rdq;
      rdv_ff      <= nxt_rdv;
      rdd_ff      <= nxt_rdd;
    end
  end

  // Counter storage for all ports
  stats_ram u_ram (
    .mclk_i    (mclk_i),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_addr),
    .wr_data_i (wr_data),
    .rd_addr_i (rd_addr),
    .rd_data_o (ram_q)
  );

  // Outputs straight from flip-flops; ready_o is decoded from st_ff
  assign rd_valid_o     = rdv_ff;
  assign rd_data_o      = rdd_ff;
  assign port_suspend_o = susp_ff;
  assign ready_o        = (st_ff == ST_RUN);

endmodule : port_traffic_statistics

// *** sim/port_traffic_statistics_assertions.sv ***
/*
  Checker: read timing, ready after clear and suspend flags.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module port_traffic_statistics_checker
  import stats_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  // Read port and status
  input  wire logic                 rd_req_i,
  input  wire logic                 rd_valid_o,
  input  wire logic [CNT_W-1:0]     rd_data_o,
  input  wire logic                 ready_o,
  // Address events and suspend flags
  input  wire logic [NUM_PORTS-1:0] addr_secure_dup_i,
  input  wire logic [NUM_PORTS-1:0] port_suspend_o
);
  logic                 rd_take;      // Read accepted this cycle
  logic [NUM_PORTS-1:0] dup_seen_ff;  // Ports that reported a duplicate
  logic [15:0]          age_ff;       // Cycles since reset release

  assign rd_take = rd_req_i & ready_o;

  // Sticky record of duplicates and a saturating age counter
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dup_seen_ff <= '0;
      age_ff      <= 16'h0000;
    end else begin
      dup_seen_ff <= dup_seen_ff | addr_secure_dup_i;
      if (age_ff != 16'hffff) begin
        age_ff <= age_ff + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_RD_ANSWER: assert property (rd_take |-> ##2 rd_valid_o)
    else $error("read not answered");
  AST_RD_ONLY_ASKED: assert property (rd_valid_o |-> $past(rd_take, 2))
    else $error("valid without request");
  AST_RD_DATA_HOLD: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved");
  AST_READY_STICKY: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  AST_READY_LATE: assert property ($rose(ready_o) |-> age_ff >= 16'h01f4)
    else $error("ready too early");
  AST_READY_BOUND: assert property ($fell(reset_i) |-> ##[500:600] ready_o)
    else $error("ready too late");
  AST_SUSPEND_CAUSE: assert property (port_suspend_o != '0 |->
    (port_suspend_o & ~dup_seen_ff) == '0)
    else $error("suspend without duplicate");
  AST_SUSPEND_STICKY: assert property (port_suspend_o != '0 |=>
    (port_suspend_o & $past(port_suspend_o)) == $past(port_suspend_o))
    else $error("suspend cleared");
  AST_SUSPEND_SOON: assert property (addr_secure_dup_i != '0 |->
    ##[1:300] ((port_suspend_o & dup_seen_ff) == dup_seen_ff))
    else $error("duplicate not suspended");
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset_i |=>
    (!rd_valid_o && !ready_o && port_suspend_o == '0))
    else $error("outputs not idle in reset");

  // Main scenarios reached
  COV_READ: cover property (rd_take ##2 rd_valid_o);
  COV_READY: cover property ($rose(ready_o));
  COV_SUSPEND: cover property ($rose(port_suspend_o != '0));
endmodule : port_traffic_statistics_checker

bind port_traffic_statistics port_traffic_statistics_checker chk_u (
  .mclk_i, .reset_i, .rd_req_i, .rd_valid_o, .rd_data_o, .ready_o,
  .addr_secure_dup_i, .port_suspend_o);

// *** sim/port_traffic_statistics_tb.sv ***
/*
  Bench: random rounds of frames and MAC events, then every counter
  is read back and compared.
  Assumes the package and design are compiled first.
*/
`timescale 1ns/10ps
module port_traffic_statistics_tb
  import stats_pkg::*;
();
  logic mclk_i, reset_i, long_frames_i, rd_req_i, rd_valid_o, ready_o;
  logic [NUM_PORTS-1:0] fast_mode_i, rx_done_i, rx_good_i, rx_bcast_i;
  logic [NUM_PORTS-1:0] rx_mcast_i, rx_align_err_i, rx_code_err_i;
  logic [NUM_PORTS-1:0] rx_discard_i, tx_done_i, tx_bcast_i, tx_mcast_i;
  logic [NUM_PORTS-1:0] tx_deferred_i, tx_single_col_i, tx_multi_col_i;
  logic [NUM_PORTS-1:0] tx_attempt_start_i, tx_carrier_lost_i, tx_jam_i;
  logic [NUM_PORTS-1:0] tx_late_col_i, tx_excess_col_i, addr_secure_dup_i;
  logic [NUM_PORTS-1:0] addr_learned_i, port_suspend_o, exp_susp;
  logic [NUM_PORTS*LEN_W-1:0] rx_len_i, tx_len_i;
  logic [PORT_W-1:0]          rd_port_i;
  logic [CNT_SEL_W-1:0]       rd_cnt_i;
  logic [CNT_W-1:0]           rd_data_o;
  logic [CNT_W-1:0]           exp_cnt [NUM_PORTS][NUM_CNT]; // Model
  logic [LEN_W-1:0]           corner [15] = '{11'h03f, LEN_64, LEN_65,
    LEN_127, LEN_128, LEN_255, LEN_256, LEN_511, LEN_512, LEN_1023,
    LEN_1024, LEN_1518, 11'h5ef, LEN_1535, 11'h600}; // Bucket edges
  integer seed = 97;
  int     num_errors = 0;
  int     n_compared = 0;
  int     cycles = 0;

  port_traffic_statistics dut_u (
    .mclk_i, .reset_i, .long_frames_i, .fast_mode_i, .rx_done_i,
    .rx_good_i, .rx_bcast_i, .rx_mcast_i, .rx_align_err_i, .rx_code_err_i,
    .rx_discard_i, .rx_len_i, .tx_done_i, .tx_bcast_i, .tx_mcast_i,
    .tx_deferred_i, .tx_single_col_i, .tx_multi_col_i, .tx_len_i,
    .tx_attempt_start_i, .tx_carrier_lost_i, .tx_jam_i, .tx_late_col_i,
    .tx_excess_col_i, .addr_secure_dup_i, .addr_learned_i, .rd_req_i,
    .rd_port_i, .rd_cnt_i, .rd_valid_o, .rd_data_o, .port_suspend_o,
    .ready_o);

  // Clock, 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [CNT_W-1:0] seen,
                       input logic [CNT_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Expected counter bump by one event
  function automatic void bump(input int p, input logic [CNT_SEL_W-1:0] c);
    exp_cnt[p][c] = exp_cnt[p][c] + 32'h0000_0001;
  endfunction : bump

  // Length buckets shared by both directions
  function automatic void bump_len(input int p, input logic [LEN_W-1:0] n);
    if (n == LEN_64) bump(p, C_LEN_64);
    else if (n >= LEN_65 && n <= LEN_127) bump(p, C_LEN_65_127);
    else if (n >= LEN_128 && n <= LEN_255) bump(p, C_LEN_128_255);
    else if (n >= LEN_256 && n <= LEN_511) bump(p, C_LEN_256_511);
    else if (n >= LEN_512 && n <= LEN_1023) bump(p, C_LEN_512_1K);
    else if (n >= LEN_1024 && n <= (long_frames_i ? LEN_1535 : LEN_1518))
      bump(p, C_LEN_1K_MAX);
  endfunction : bump_len

  task automatic clear_pulses();
    {rx_done_i, tx_done_i, tx_attempt_start_i, tx_carrier_lost_i, tx_jam_i,
     tx_late_col_i, tx_excess_col_i, addr_secure_dup_i, addr_learned_i} = '0;
  endtask : clear_pulses

  task automatic wait_ready();
    for (int n = 0; n < 800 && ready_o !== 1'b1; n++) @(negedge mclk_i);
  endtask : wait_ready

  // One counter read; answer two cycles after the request
  task automatic rd(input int p, input int c, output logic [CNT_W-1:0] d);
    rd_req_i = 1'b1;
    rd_port_i = PORT_W'(p);
    rd_cnt_i = CNT_SEL_W'(c);
    @(negedge mclk_i);
    rd_req_i = 1'b0;
    for (int n = 0; n < 8 && rd_valid_o !== 1'b1; n++) @(negedge mclk_i);
    d = rd_data_o;
  endtask : rd

  task automatic check_all();
    logic [CNT_W-1:0] d;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int c = 0; c < NUM_CNT; c++) begin
        rd(p, c, d);
        check($sformatf("port %0d counter %0d", p, c), d, exp_cnt[p][c]);
      end
    end
    check("suspend", CNT_W'(port_suspend_o), CNT_W'(exp_susp));
  endtask : check_all

  // Random events on every port at once, then drain and compare
  task automatic run_round(input int rnd);
    logic [31:0]          r;
    logic [LEN_W-1:0]     len;
    logic [LEN_W-1:0]     lim;
    logic [NUM_PORTS-1:0] crs;
    r = $random(seed);
    long_frames_i = r[0];
    fast_mode_i = r[10:1];
    lim = long_frames_i ? LEN_1535 : LEN_1518;
    for (int p = 0; p < NUM_PORTS; p++) begin
      r = $random(seed);
      len = r[0] ? corner[r[4:1] % 15] : r[15:5];
      if (r[16]) begin
        rx_done_i[p] = 1'b1;
        rx_len_i[p*LEN_W +: LEN_W] = len;
        rx_good_i[p] = r[17] | r[18];
        rx_bcast_i[p] = r[19] & ~r[20];
        rx_mcast_i[p] = r[20] & ~r[19];
        rx_align_err_i[p] = ~rx_good_i[p] & r[21];
        rx_code_err_i[p] = ~rx_good_i[p] & r[22];
        rx_discard_i[p] = r[23];
        if (rx_good_i[p] && rx_bcast_i[p]) bump(p, C_RX_BCAST);
        if (rx_good_i[p] && rx_mcast_i[p]) bump(p, C_RX_MCAST);
        if (rx_good_i[p]) bump(p, C_RX_GOOD);
        if (rx_good_i[p] && len > lim) bump(p, C_OVERSIZE);
        if (r[23]) bump(p, C_FILTERED);
        if (rx_align_err_i[p] || (rx_code_err_i[p] && fast_mode_i[p] &&
            p < FIRST_SLOW_PORT)) bump(p, C_ALIGN_CODE);
        exp_cnt[p][C_NET_OCTETS] += CNT_W'(len);
      end else begin
        tx_done_i[p] = 1'b1;
        tx_len_i[p*LEN_W +: LEN_W] = len;
        tx_bcast_i[p] = r[19] & ~r[20];
        tx_mcast_i[p] = r[20] & ~r[19];
        {tx_deferred_i[p], tx_single_col_i[p], tx_multi_col_i[p]} = r[23:21];
        bump(p, C_TX_GOOD);
        if (tx_bcast_i[p]) bump(p, C_TX_BCAST);
        if (tx_mcast_i[p]) bump(p, C_TX_MCAST);
        if (r[23]) bump(p, C_DEFERRED);
        if (r[22]) bump(p, C_SINGLE_COL);
        if (r[21] && !r[22]) bump(p, C_MULTI_COL);
      end
      bump_len(p, len);
      tx_attempt_start_i[p] = 1'b1;
      crs[p] = r[24];
      {tx_jam_i[p], tx_late_col_i[p], tx_excess_col_i[p]} = r[27:25];
      addr_secure_dup_i[p] = r[28] & r[29] & r[30];
      addr_learned_i[p] = r[31];
      if (r[24]) bump(p, C_CRS_ERR);
      if (r[27] && p >= FIRST_SLOW_PORT) bump(p, C_COLLISIONS);
      if (r[26]) bump(p, C_LATE_COL);
      if (r[25]) bump(p, C_EXCESS_COL);
      if (addr_secure_dup_i[p]) bump(p, C_ADDR_DUP);
      if (addr_secure_dup_i[p]) bump(p, C_ADDR_CHG);
      exp_susp[p] = exp_susp[p] | addr_secure_dup_i[p];
      if (r[31]) bump(p, C_ADDR_CHG);
    end
    @(negedge mclk_i);
    clear_pulses();
    tx_carrier_lost_i = crs;
    @(negedge mclk_i);
    tx_carrier_lost_i = '0;
    wait_ready();
    repeat (300) @(negedge mclk_i);
    check_all();
    $display("round %0d done", rnd);
  endtask : run_round

  task automatic reset_dut();
    reset_i = 1'b1;
    foreach (exp_cnt[p, c]) exp_cnt[p][c] = CNT_RESET;
    exp_susp = '0;
    repeat (3) @(negedge mclk_i);
    reset_i = 1'b0;
  endtask : reset_dut

  // Main sequence
  initial begin
    clear_pulses();
    {rx_good_i, rx_bcast_i, rx_mcast_i, rx_align_err_i, rx_code_err_i,
     rx_discard_i, tx_bcast_i, tx_mcast_i, tx_deferred_i, tx_single_col_i,
     tx_multi_col_i, rx_len_i, tx_len_i, fast_mode_i, long_frames_i,
     rd_req_i, rd_port_i, rd_cnt_i} = '0;
    reset_dut();
    repeat (8) @(negedge mclk_i);
    check("ready in clear", CNT_W'(ready_o), CNT_W'(1'b0));
    for (int i = 0; i < 24; i++) run_round(i);
    // Carrier toggling twice within one attempt counts once
    tx_attempt_start_i[3] = 1'b1;
    @(negedge mclk_i);
    tx_attempt_start_i[3] = 1'b0;
    tx_carrier_lost_i[3] = 1'b1;
    @(negedge mclk_i);
    tx_carrier_lost_i[3] = 1'b0;
    repeat (300) @(negedge mclk_i);
    tx_carrier_lost_i[3] = 1'b1;
    @(negedge mclk_i);
    tx_carrier_lost_i[3] = 1'b0;
    bump(3, C_CRS_ERR);
    repeat (300) @(negedge mclk_i);
    check_all();
    $display("carrier test done");
    // Second reset clears every counter and flag
    reset_dut();
    wait_ready();
    check_all();
    $display("reset test done");
    stop_test();
  end
endmodule : port_traffic_statistics_tb
